// ---- rtl/sleep_ctrl_defines.vh ----
// Register offsets, field positions, reset values and timing counts for the sleep controller
`ifndef SLEEP_CTRL_DEFINES_VH
`define SLEEP_CTRL_DEFINES_VH

// =====================================================================
// Register byte addresses on APB
`define OFS_SLEEP_CTRL      12'h000
`define OFS_MCU_CTRL        12'h004
`define OFS_POWER_RED       12'h008
`define OFS_STATUS          12'h00C
`define OFS_WAKE_CFG        12'h010

// =====================================================================
// Field positions
`define SLP_ARM_BIT         0
`define SLP_MODE_LSB        1
`define BOD_OFF_BIT         6
`define BOD_WEN_BIT         5

// =====================================================================
// Reset values
`define SLEEP_CTRL_RST      4'h0
`define POWER_RED_RST       8'h00

// =====================================================================
// Mode codes
`define MODE_IDLE           3'h0
`define MODE_ADCNR          3'h1
`define MODE_PDOWN          3'h2
`define MODE_PSAVE          3'h3
`define MODE_STBY           3'h6

// =====================================================================
// Timing: clock 250 MHz, BOD_WAKE_NS in ns, other counts in clock cycles
`define CLK_MHZ             250
`define BOD_WAKE_NS         60000
`define BOD_WAKE_CYC        ((`BOD_WAKE_NS * `CLK_MHZ + 999) / 1000)
`define BOD_SEQ_WIN         3'h4
`define BOD_ACT_DLY         3'h3
`define BOD_ACT_LEN         3'h3
`define IRQ_HOLD_CYC        32'h4
`define STBY_WAKE_CYC       32'h6

`endif

// ---- rtl/sleep_mode_power_controller.v ----
// Sleep-mode and power controller with APB register access
`timescale 1ns/10ps
`include "sleep_ctrl_defines.vh"

module sleep_mode_power_controller #(
  parameter PR_BITS     = 8,
  parameter BOD_WAKE    = `BOD_WAKE_CYC,
  parameter START_SCALE = 256
) (
  // Clock and reset
  input  wire                clk_sys,
  input  wire                rst_n,
  // APB slave
  input  wire                psel,
  input  wire                penable,
  input  wire                pwrite,
  input  wire [11:0]         paddr,
  input  wire [31:0]         pwdata,
  output reg                 pready,
  output reg  [31:0]         prdata,
  output reg                 pslverr,
  // Core handshake
  input  wire                sleep_instr,
  input  wire                irq_pending,
  output reg                 sleep_done,
  output reg                 core_hold,
  // Configuration inputs
  input  wire [3:0]          clock_source_select_fuses,
  input  wire                crystal_selected,
  input  wire                adc_enabled,
  input  wire                t2_async,
  input  wire                t2_sync,
  input  wire                disp_async,
  input  wire                disp_sync,
  input  wire [1:0]          timer2_irq_mask,
  input  wire                global_irq_en,
  // Wake sources
  input  wire                any_irq,
  input  wire                adc_done,
  input  wire                reset_wake,
  input  wire                disp_irq,
  input  wire                serial_start_irq,
  input  wire                t2_irq,
  input  wire [1:0]          t2_events,
  input  wire                store_ready_irq,
  input  wire                ext_irq_zero_level,
  input  wire                pin_change_irq,
  // Clock and power gates, high means running
  output reg                 core_clock_en,
  output reg                 flash_clock_en,
  output reg                 io_clock_en,
  output reg                 adc_clock_en,
  output reg                 async_clock_en,
  output reg                 main_osc_en,
  output reg                 timer_osc_en,
  output reg                 brownout_detector_en,
  output reg                 adc_start,
  output reg  [PR_BITS-1:0]  periph_clock_en,
  output reg  [PR_BITS-1:0]  periph_access_en
);

  // ===================================================================
  // States
  // One-hot so a stray state is caught by the default branch and sent home
  // to run; the wait counter is shared by the start-up and hold phases
  localparam ST_RUN   = 4'b0001;
  localparam ST_SLEEP = 4'b0010;
  localparam ST_START = 4'b0100;
  localparam ST_HOLD  = 4'b1000;

  reg [3:0]          state_reg;
  reg [3:0]          sleep_ctrl_reg;
  reg [PR_BITS-1:0]  power_reduction_reg;
  reg                seq_armed_reg;
  reg [2:0]          seq_cnt_reg;
  reg [2:0]          bod_dly_reg;
  reg [2:0]          bod_act_reg;
  reg                bod_off_reg;
  reg                bod_was_off_reg;
  reg [2:0]          mode_reg;
  reg [31:0]         wait_reg;
  reg                irq_wake_reg;

  wire [2:0] mode_sel  = sleep_ctrl_reg[3:1];
  wire       apb_acc   = psel & penable;
  wire       apb_wr    = apb_acc & pwrite;
  wire       bod_act   = (bod_act_reg != 3'h0);
  wire       bod_allow = (mode_sel == `MODE_PDOWN) | (mode_sel == `MODE_PSAVE) |
                         (mode_sel == `MODE_STBY);
  wire       mode_ok   = (mode_sel == `MODE_IDLE) | (mode_sel == `MODE_ADCNR) | bod_allow;
  wire [31:0] start_cyc = ({28'h0, clock_source_select_fuses} + 32'h1) * START_SCALE;

  // ===================================================================
  // Wake qualification per mode
  // Wake levels are sampled every cycle; a source that drops its level
  // before the sleeping state sees it is simply lost
  reg wake_req;
  reg wake_is_irq;
  always @* begin
    wake_req    = 1'b0;
    wake_is_irq = 1'b1;
    case (mode_reg)
      `MODE_IDLE:  wake_req = any_irq | reset_wake;
      `MODE_ADCNR: wake_req = adc_done | reset_wake | disp_irq | serial_start_irq |
                              t2_irq | store_ready_irq | ext_irq_zero_level |
                              pin_change_irq;
      `MODE_PSAVE: wake_req = reset_wake | serial_start_irq | ext_irq_zero_level |
                              pin_change_irq | disp_irq |
                              (global_irq_en & |(t2_events & timer2_irq_mask));
      default:     wake_req = reset_wake | serial_start_irq | ext_irq_zero_level |
                              pin_change_irq;
    endcase
    if (reset_wake)
      wake_is_irq = 1'b0;
  end

  // ===================================================================
  // Timed write sequence for bod_sleep_off
  // The unlock window counts down from the first write; a second unlock
  // write restarts it, and the set write must land while it is still open
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      seq_armed_reg <= 1'b0;
      seq_cnt_reg   <= 3'h0;
      bod_dly_reg   <= 3'h0;
      bod_act_reg   <= 3'h0;
    end else begin
      if (seq_cnt_reg != 3'h0)
        seq_cnt_reg <= seq_cnt_reg - 3'h1;
      else
        seq_armed_reg <= 1'b0;
      if (apb_wr && paddr == `OFS_MCU_CTRL) begin
        if (pwdata[`BOD_OFF_BIT] && pwdata[`BOD_WEN_BIT]) begin
          seq_armed_reg <= 1'b1;
          seq_cnt_reg   <= `BOD_SEQ_WIN;
        end else if (pwdata[`BOD_OFF_BIT] && seq_armed_reg) begin
          seq_armed_reg <= 1'b0;
          seq_cnt_reg   <= 3'h0;
          bod_dly_reg   <= `BOD_ACT_DLY;
        end
      end
      if (bod_dly_reg != 3'h0) begin
        bod_dly_reg <= bod_dly_reg - 3'h1;
        if (bod_dly_reg == 3'h1)
          bod_act_reg <= `BOD_ACT_LEN;
      end else if (bod_act_reg != 3'h0)
        bod_act_reg <= bod_act_reg - 3'h1;
    end
  end

  // ===================================================================
  // Registers and sleep sequencer
  // Standby without a crystal and reserved mode codes are refused: the
  // core simply carries on, as after an unarmed sleep
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      state_reg           <= ST_RUN;
      sleep_ctrl_reg      <= `SLEEP_CTRL_RST;
      power_reduction_reg <= `POWER_RED_RST;
      bod_off_reg         <= 1'b0;
      bod_was_off_reg     <= 1'b0;
      mode_reg            <= `MODE_IDLE;
      wait_reg            <= 32'h0;
      irq_wake_reg        <= 1'b0;
      sleep_done          <= 1'b0;
    end else begin
      sleep_done <= 1'b0;
      if (apb_wr && paddr == `OFS_SLEEP_CTRL)
        sleep_ctrl_reg <= pwdata[3:0];
      if (apb_wr && paddr == `OFS_POWER_RED)
        power_reduction_reg <= pwdata[PR_BITS-1:0];
      case (state_reg)
        ST_RUN: begin
          if (sleep_instr && sleep_ctrl_reg[`SLP_ARM_BIT] && mode_ok &&
              !(mode_sel == `MODE_STBY && !crystal_selected)) begin
            state_reg <= ST_SLEEP;
            mode_reg  <= mode_sel;
            bod_off_reg     <= bod_act & bod_allow;
            bod_was_off_reg <= bod_act & bod_allow;
          end else if (sleep_instr) begin
            sleep_done <= 1'b1;
          end
        end
        ST_SLEEP: begin
          if (wake_req) begin
            state_reg    <= ST_START;
            irq_wake_reg <= wake_is_irq;
            bod_off_reg  <= 1'b0;
            if (mode_reg == `MODE_STBY)
              wait_reg <= `STBY_WAKE_CYC;
            else if (mode_reg == `MODE_PDOWN || mode_reg == `MODE_PSAVE)
              wait_reg <= start_cyc;
            else
              wait_reg <= 32'h1;
            if (bod_was_off_reg && BOD_WAKE > start_cyc)
              wait_reg <= BOD_WAKE;
          end
        end
        ST_START: begin
          if (wait_reg > 32'h1)
            wait_reg <= wait_reg - 32'h1;
          else begin
            state_reg <= ST_HOLD;
            // A reset wake skips the extra hold; only an interrupt wake needs it
            // hold lasts four cycles on irq wake, one on reset wake
            wait_reg  <= irq_wake_reg ? `IRQ_HOLD_CYC : 32'h1;
          end
        end
        ST_HOLD: begin
          if (wait_reg > 32'h1)
            wait_reg <= wait_reg - 32'h1;
          else begin
            state_reg       <= ST_RUN;
            bod_was_off_reg <= 1'b0;
            sleep_done      <= 1'b1;
          end
        end
        default: state_reg <= ST_RUN;
      endcase
    end
  end

  // ===================================================================
  // Clock gating per mode, registered so outputs come from flops
  // Gates follow the state one cycle late, as core_hold does; both change at
  // the same edge, so a late gate costs power for a cycle but never correctness
  wire asleep = (state_reg == ST_SLEEP);
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      core_clock_en        <= 1'b1;
      flash_clock_en       <= 1'b1;
      io_clock_en          <= 1'b1;
      adc_clock_en         <= 1'b1;
      async_clock_en       <= 1'b1;
      main_osc_en          <= 1'b1;
      timer_osc_en         <= 1'b1;
      brownout_detector_en <= 1'b1;
      adc_start            <= 1'b0;
      core_hold            <= 1'b0;
    end else begin
      core_hold            <= (state_reg != ST_RUN);
      brownout_detector_en <= ~bod_off_reg;
      adc_start <= (state_reg == ST_RUN) && sleep_instr && sleep_ctrl_reg[`SLP_ARM_BIT] &&
                   adc_enabled && (mode_sel == `MODE_IDLE || mode_sel == `MODE_ADCNR);
      core_clock_en  <= 1'b1;
      flash_clock_en <= 1'b1;
      io_clock_en    <= 1'b1;
      adc_clock_en   <= 1'b1;
      async_clock_en <= 1'b1;
      main_osc_en    <= 1'b1;
      timer_osc_en   <= 1'b1;
      if (asleep) begin
        core_clock_en  <= 1'b0;
        flash_clock_en <= 1'b0;
        case (mode_reg)
          `MODE_IDLE: io_clock_en <= 1'b1;
          `MODE_ADCNR: io_clock_en <= 1'b0;
          // Main clock stays only for a synchronously clocked timer2 or display
          // power-save, unused oscillators stop
          `MODE_PSAVE: begin
            io_clock_en    <= 1'b0;
            adc_clock_en   <= 1'b0;
            async_clock_en <= t2_async | disp_async;
            timer_osc_en   <= t2_async | disp_async;
            main_osc_en    <= t2_sync | disp_sync;
          end
          `MODE_STBY: begin
            io_clock_en    <= 1'b0;
            adc_clock_en   <= 1'b0;
            async_clock_en <= 1'b0;
            timer_osc_en   <= 1'b0;
          end
          default: begin
            io_clock_en    <= 1'b0;
            adc_clock_en   <= 1'b0;
            async_clock_en <= 1'b0;
            timer_osc_en   <= 1'b0;
            main_osc_en    <= 1'b0;
          end
        endcase
      end
    end
  end

  // ===================================================================
  // Per-peripheral gating from the power reduction bits
  // The peripheral keeps its own flops; only its clock and bus access
  // are withheld, so clearing the bit resumes it where it stopped
  genvar gi;
  generate
    for (gi = 0; gi < PR_BITS; gi = gi + 1) begin : g_pr
      always @(posedge clk_sys) begin
        if (!rst_n) begin
          periph_clock_en[gi]  <= 1'b1;
          periph_access_en[gi] <= 1'b1;
        end else begin
          // stop and block, resume on clear
          periph_clock_en[gi]  <= ~power_reduction_reg[gi] & io_clock_en;
          periph_access_en[gi] <= ~power_reduction_reg[gi];
        end
      end
    end
  endgenerate

  // ===================================================================
  // APB read path, zero-wait; unmapped reads zero with error
  // Read data is captured at the setup edge, so a read sees the state one
  // cycle before the access edge; writes land at the access edge only
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      pready  <= 1'b0;
      prdata  <= 32'h0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
      if (psel && !penable) begin
        case (paddr)
          `OFS_SLEEP_CTRL: prdata <= {28'h0, sleep_ctrl_reg};
          `OFS_MCU_CTRL:   prdata <= {25'h0, bod_act, seq_armed_reg, 5'h0};
          `OFS_POWER_RED:  prdata <= {{(32-PR_BITS){1'b0}}, power_reduction_reg};
          `OFS_STATUS:     prdata <= {24'h0, bod_was_off_reg, mode_reg, state_reg};
          default:         pslverr <= 1'b1;
        endcase
      end
    end
  end

endmodule

// ---- test/sleep_ctrl_chk.sv ----
// Port-level assertions for the sleep-mode power controller
`timescale 1ns/10ps
module sleep_ctrl_chk (
  // Clock, reset and APB
  input wire        clk_sys,
  input wire        rst_n,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire        pready,
  input wire        pslverr,
  // Core side and configuration
  input wire        sleep_instr,
  input wire        sleep_done,
  input wire        crystal_selected,
  input wire        adc_enabled,
  // Gates
  input wire        core_clock_en,
  input wire        flash_clock_en,
  input wire        io_clock_en,
  input wire        adc_clock_en,
  input wire        main_osc_en,
  input wire        brownout_detector_en,
  input wire        adc_start
);
  logic [3:0] ctl_reg;
  wire        go;
  wire [2:0]  md;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // ==================================================================
  // Shadow of the sleep control word, taken at the write edge only
  always @(posedge clk_sys)
    if (!rst_n) ctl_reg <= 4'h0;
    else if (psel && penable && pready && pwrite && paddr == 12'h000) ctl_reg <= pwdata[3:0];
  // Armed sleep request and the mode it selects
  assign go = sleep_instr && ctl_reg[0];
  assign md = ctl_reg[3:1];
  // ==================================================================
  // Assertions
  a_apb_answer: assert property (psel && !penable |=> pready)
    else $error("pready missing after setup");
  a_ready_single: assert property (pready |=> !pready)
    else $error("pready held longer than one cycle");
  a_bad_addr: assert property (pready && paddr > 12'h010 |-> pslverr)
    else $error("unmapped access without pslverr");
  a_idle_gates: assert property (go && md == 3'h0 |-> ##[1:2]
    (!core_clock_en && !flash_clock_en && io_clock_en && adc_clock_en))
    else $error("idle gating wrong");
  a_adcnr_gates: assert property (go && md == 3'h1 |-> ##[1:2]
    (!io_clock_en && !core_clock_en && adc_clock_en))
    else $error("adc noise gating wrong");
  a_pdown_gates: assert property (go && md == 3'h2 |-> ##[1:2]
    (!main_osc_en && !adc_clock_en && !io_clock_en))
    else $error("power-down gating wrong");
  a_stby_osc: assert property (go && md == 3'h6 && crystal_selected |-> ##[1:2]
    (main_osc_en && !core_clock_en))
    else $error("standby oscillator wrong");
  a_unarmed_skip: assert property (sleep_instr && !ctl_reg[0] |=> sleep_done && core_clock_en)
    else $error("unarmed sleep not skipped");
  a_bod_back: assert property (sleep_done |-> brownout_detector_en)
    else $error("detector off at resume");
  a_adc_kick: assert property (go && md[2:1] == 2'b00 && adc_enabled |=> adc_start)
    else $error("no conversion start on sleep");
endmodule

bind sleep_mode_power_controller sleep_ctrl_chk u_sleep_ctrl_chk (.clk_sys, .rst_n, .psel,
  .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr, .sleep_instr, .sleep_done,
  .crystal_selected, .adc_enabled, .core_clock_en, .flash_clock_en, .io_clock_en,
  .adc_clock_en, .main_osc_en, .brownout_detector_en, .adc_start);

// ---- test/wake_src_model.sv ----
// Model of the core and the wake sources around the sleep controller
`timescale 1ns/10ps
module wake_src_model (
  // Clock and reset
  input  wire         clk_sys,
  input  wire         rst_n,
  // Bench commands
  input  wire         sleep_go,
  input  wire  [10:0] wake_cmd,
  // Controller side
  input  wire         sleep_done,
  input  wire         core_hold,
  output logic        sleep_instr,
  output logic [10:0] wake_lvl
);
  // core issues sleep
  // A held core executes nothing, so no sleep instruction while held
  always @(posedge clk_sys)
    if (!rst_n) sleep_instr <= 1'b0;
    else sleep_instr <= sleep_go && !core_hold;
  // level held long
  // A source keeps its level until the core resumes, so a short request is not lost
  always @(posedge clk_sys)
    if (!rst_n) wake_lvl <= 11'h000;
    else if (sleep_done) wake_lvl <= wake_cmd;
    else wake_lvl <= wake_lvl | wake_cmd;
endmodule

// ---- test/sleep_mode_power_controller_tb_top.sv ----
// Self-checking bench for the sleep-mode power controller
`timescale 1ns/10ps
`include "sleep_ctrl_defines.vh"
module sleep_mode_power_controller_tb_top;
  logic        clk_sys, rst_n, psel, penable, pwrite, pready, pslverr, er, b;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        sleep_go, sleep_instr, sleep_done, core_hold, adc_en, t2_async, glob;
  logic        xtal, t2_sync, disp_async, disp_sync;
  logic [1:0]  mask;
  logic [10:0] wake_cmd, wl;
  logic        cc, fc, ic, ac, yc, mo, to, brownout_detector, adc_start;
  logic [7:0]  pce, pae;
  logic [4:0]  g;
  wire  [4:0]  gates = {cc, fc, ic, ac, mo};
  int          miscompares, n_checks, cyc, n;
  sleep_mode_power_controller #(.BOD_WAKE(20), .START_SCALE(2)) u_sleep_mode_power_controller (
    .clk_sys, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata,
    .pslverr, .sleep_instr, .irq_pending(1'b0), .sleep_done, .core_hold,
    .clock_source_select_fuses(4'h3), .crystal_selected(xtal), .adc_enabled(adc_en),
    .t2_async, .t2_sync, .disp_async, .disp_sync,
    .timer2_irq_mask(mask), .global_irq_en(glob), .any_irq(wl[0]), .adc_done(wl[1]),
    .reset_wake(wl[2]), .disp_irq(wl[3]), .serial_start_irq(wl[4]), .t2_irq(wl[5]),
    .t2_events(wl[10:9]), .store_ready_irq(wl[6]), .ext_irq_zero_level(wl[7]),
    .pin_change_irq(wl[8]), .core_clock_en(cc), .flash_clock_en(fc), .io_clock_en(ic),
    .adc_clock_en(ac), .async_clock_en(yc), .main_osc_en(mo), .timer_osc_en(to),
    .brownout_detector_en(brownout_detector), .adc_start, .periph_clock_en(pce), .periph_access_en(pae));
  wake_src_model u_wake_src_model (.clk_sys, .rst_n, .sleep_go, .wake_cmd, .sleep_done,
    .core_hold, .sleep_instr, .wake_lvl(wl));
  // ==================================================================
  // Shared tasks
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    n_checks++;
    if (s !== e) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask
  // One APB transfer; request held until pready is seen high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic arm(input logic [2:0] m);
    apb(1'b1, `OFS_SLEEP_CTRL, {28'h0000000, m, 1'b1});
  endtask
  // Sleep request; n stays 5 unless the core is let go at once
  task automatic go_sleep();
    sleep_go <= 1'b1;
    @(posedge clk_sys);
    sleep_go <= 1'b0;
    n = 0;
    while (sleep_done !== 1'b1 && n < 5) begin
      @(posedge clk_sys);
      n++;
    end
    g = gates;
    b = brownout_detector;
  endtask
  // Raise a wake source and count cycles until the core resumes
  task automatic wake(input logic [10:0] w);
    wake_cmd <= w;
    @(posedge clk_sys);
    wake_cmd <= 11'h000;
    n = 0;
    while (sleep_done !== 1'b1 && n < 400) begin
      @(posedge clk_sys);
      n++;
    end
  endtask
  // ==================================================================
  // Scenarios
  task automatic t_regs();
    apb(1'b0, `OFS_MCU_CTRL, 32'h0);
    chk("mcu_ctrl reset", 32'h0, rd);
    apb(1'b0, `OFS_POWER_RED, 32'h0);
    chk("power_red reset", 32'h0, rd);
    apb(1'b1, 12'h020, 32'hFF);
    apb(1'b0, 12'h020, 32'h0);
    chk("unmapped err", 32'h1, er);
    apb(1'b1, `OFS_SLEEP_CTRL, 32'h4);
    apb(1'b0, `OFS_SLEEP_CTRL, 32'h0);
    chk("sleep_ctrl rw", 32'h4, rd);
    go_sleep();
    chk("unarmed done", 32'h1, n < 5);
  endtask
  task automatic t_modes();
    adc_en <= 1'b1;
    arm(`MODE_IDLE);
    go_sleep();
    chk("idle gates", 32'h07, g);
    chk("idle core held", 32'h1, core_hold);
    wake(11'h001);
    chk("idle wake", 32'h1, n >= 4 && n < 20);
    arm(`MODE_ADCNR);
    go_sleep();
    chk("adcnr gates", 32'h03, g);
    wake(11'h002);
    chk("adcnr wake", 32'h1, n < 20);
    adc_en <= 1'b0;
    arm(`MODE_PDOWN);
    go_sleep();
    chk("pdown gates", 32'h00, g);
    wake(11'h008);
    chk("pdown refuse", 32'd400, n);
    wake(11'h100);
    chk("pdown wake", 32'h1, n >= 8 && n < 60);
  endtask
  task automatic t_save_stby();
    t2_async <= 1'b1;
    mask <= 2'b01;
    glob <= 1'b1;
    arm(`MODE_PSAVE);
    go_sleep();
    chk("psave gates", 32'h00, g);
    chk("psave timer osc", 32'h1, to);
    chk("psave async clk", 32'h1, yc);
    wake(11'h200);
    chk("psave wake", 32'h1, n < 60);
    // display kept running on the synchronous clock
    t2_async <= 1'b0;
    disp_sync <= 1'b1;
    arm(`MODE_PSAVE);
    go_sleep();
    chk("psave sync gates", 32'h01, g);
    chk("psave osc off", 32'h0, to);
    wake(11'h008);
    chk("psave disp wake", 32'h1, n < 60);
    disp_sync <= 1'b0;
    xtal <= 1'b0;
    arm(`MODE_STBY);
    go_sleep();
    chk("stby no crystal", 32'h1F, g);
    xtal <= 1'b1;
    arm(`MODE_STBY);
    go_sleep();
    chk("stby gates", 32'h01, g);
    wake(11'h010);
    chk("stby wake", 32'h1, n <= 12);
  endtask
  task automatic t_bod(input logic first, input int gap, input logic off);
    arm(`MODE_PDOWN);
    if (first) apb(1'b1, `OFS_MCU_CTRL, 32'h60);
    apb(1'b1, `OFS_MCU_CTRL, 32'h40);
    repeat (gap) @(posedge clk_sys);
    go_sleep();
    chk("bod in sleep", !off, b);
    wake(11'h100);
    chk("bod wake time", 32'h1, (n >= 20) == off);
    chk("bod resumed", 32'h1, brownout_detector);
  endtask
  task automatic t_prr();
    // bench software leaves the peripherals idle before stopping clocks
    apb(1'b1, `OFS_POWER_RED, 32'h05);
    repeat (2) @(posedge clk_sys);
    chk("pclk stop", 32'hFA, pce);
    chk("pacc stop", 32'hFA, pae);
    apb(1'b1, `OFS_POWER_RED, 32'h00);
    repeat (2) @(posedge clk_sys);
    chk("pclk run", 32'hFF, pce);
    chk("pacc run", 32'hFF, pae);
  endtask
  task end_sim;
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // ==================================================================
  // Clock, hang guard and main sequence
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  // Long sleeps that never end would stall the run, so cap it
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      end_sim;
    end
  end
  initial begin
    {rst_n, psel, penable, pwrite, sleep_go, adc_en, t2_async, glob} = 8'h00;
    {paddr, pwdata, mask, wake_cmd} = 57'h0;
    {t2_sync, disp_async, disp_sync} = 3'h0;
    xtal = 1'b1;
    repeat (6) @(posedge clk_sys);
    rst_n <= 1'b1;
    t_regs();
    t_modes();
    t_save_stby();
    t_bod(1'b1, 2, 1'b1);
    t_bod(1'b0, 2, 1'b0);
    t_bod(1'b1, 12, 1'b0);
    t_prr();
    end_sim;
  end
endmodule
